// *** ipr_pkg.sv ***
/*
 * Constants, priority numbers and vector mapping for the interruption
 * priority resolver. Assumes a core that presents one bundle of
 * detected conditions per cycle on the core clock.
 */
// Contract
// [RL1] Deliver one interruption at a time, fixed order
// [RL2] Lowest-numbered slot wins within a bundle
// [RL3] Drop lower faults/traps, keep lower interrupts pending
// [RL4] Predicated-off sensitive interruptions are suppressed
// [RL5] Incomplete-frame faults behave as register-stack faults
// [RL6] Incomplete-frame only from return-triggered stack loads
// [RL7] Legacy traps ordered 77 to 84
// [RL8] Unimplemented address reported by one chosen style
// [RL9] Legacy float error faults on next wait
// [RL10] Unimplemented address on check ranks lowest
// [RL11] Legacy classes keep fixed order between them
// [RL12] Fetch-class faults follow fixed order on one page
// [RL13] Start beyond limit: code fetch beats translation
// [RL14] Limit at boundary: code fetch beats second page
// [RL15] Fifteen prefix bytes: length fault beats second page
// [RL16] Fewer prefix bytes: either order allowed
// [RL17] Fixed data fault order for single references
// [RL18] First data reference checked before later ones
// [RL19] One page fully checked before the other
// [RL20] Concurrent legacy traps reported together via code
// [RL21] Deferred speculative faults never take part
// [RL22] Encoder orders by priority, then slot
package ipr_pkg;

	// ==================================================
	// Widths
	localparam int PRIO_W = 7;
	localparam int SLOT_W = 2;
	localparam int NSLOT = 3;
	localparam int NTRAP = 8;
	localparam int NINT = 16;
	localparam int INTV_W = 4;

	// ==================================================
	// Fixed priority numbers (lower number wins)
	localparam logic [6:0] PRIO_NONE = 7'h7F;
	localparam logic [6:0] IFRAME_LO = 7'h07;
	localparam logic [6:0] IFRAME_HI = 7'h12;
	localparam logic [6:0] STACK_FIRST = 7'h2D;
	localparam logic [6:0] STACK_SKIP = 7'h3C;
	localparam logic [6:0] STACK_OFS_LO = 7'h2B;
	localparam logic [6:0] STACK_OFS_HI = 7'h2C;
	localparam logic [6:0] LG_TRAP_BASE = 7'h4D;
	localparam logic [6:0] LG_DEBUG = 7'h52;
	localparam logic [6:0] UIA_CHECK = 7'h55;
	localparam logic [6:0] PRIO_LEN_MIN = 7'h0F;

	// Plain defaults for numbers not fixed elsewhere (arbitrary)
	localparam logic [6:0] PRIO_INT = 7'h04;
	localparam logic [6:0] PRIO_UIA_FAULT = 7'h06;
	localparam logic [6:0] PRIO_LG_IBRK = 7'h1A;
	localparam logic [6:0] PRIO_LG_CODE = 7'h1B;
	localparam logic [6:0] PRIO_LG_ITLB = 7'h1C;
	localparam logic [6:0] PRIO_LG_LEN = 7'h20;
	localparam logic [6:0] PRIO_FP_ERR = 7'h30;
	localparam logic [6:0] PRIO_UIA_TRAP = 7'h4C;

	// Unimplemented address reporting styles
	localparam logic [1:0] UIA_ON_BRANCH = 2'h0;
	localparam logic [1:0] UIA_ON_SLOT2 = 2'h1;
	localparam logic [1:0] UIA_ON_FETCH = 2'h2;
	localparam logic [1:0] SLOT_LAST = 2'h2;

	// ==================================================
	// Vector of a priority: incomplete-frame shares stack vectors
	function automatic logic [6:0] vec_of(input logic [6:0] p);
		logic [6:0] v;
		v = p;
		if (p == IFRAME_LO) begin
			v = STACK_FIRST;
		end else if (p > IFRAME_LO && p <= IFRAME_HI) begin
			v = p + STACK_OFS_LO;
			if (v >= STACK_SKIP) begin
				v = p + STACK_OFS_HI;
			end
		end else if (p > LG_DEBUG && p < UIA_CHECK) begin
			v = LG_DEBUG;
		end
		return v;
	endfunction

endpackage

// *** ipr_resolver.sv ***
/*
 * Interruption priority resolver: gathers the conditions that a bundle
 * detects, applies legacy class ordering, and raises one winner per
 * cycle. Assumes all inputs come from core logic on ref_clk.
 */
`timescale 1ns/1ps
module ipr_resolver #(
	parameter logic [1:0] UIA_STYLE = ipr_pkg::UIA_ON_BRANCH,
	parameter bit LEN_FIRST = 1'b1
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [2:0] slotValid,
	input wire logic [20:0] slotPrio,
	input wire logic [2:0] slotIsTrap,
	input wire logic [2:0] slotPredSens,
	input wire logic [2:0] slotPred,
	input wire logic [2:0] slotDeferred,
	input wire logic [2:0] slotFromReturn,
	input wire logic intReq,
	input wire logic [3:0] intVec,
	input wire logic uiaDetect,
	input wire logic uiaOnCheck,
	input wire logic [1:0] uiaSlot,
	input wire logic lgValid,
	input wire logic lgIbrk,
	input wire logic lgCodeFault,
	input wire logic lgTlbFirst,
	input wire logic lgTlbSecond,
	input wire logic lgSpans,
	input wire logic lgStartOver,
	input wire logic lgLimitAtBound,
	input wire logic lgLenFault,
	input wire logic [3:0] lgPrefixBytes,
	input wire logic [1:0] lgRefFault,
	input wire logic [13:0] lgRefPrio,
	input wire logic [7:0] lgTraps,
	input wire logic fpErrDetect,
	input wire logic fpWaitInsn,
	output logic raiseValid,
	output logic [6:0] raisePrio,
	output logic [1:0] raiseSlot,
	output logic [6:0] raiseVector,
	output logic [7:0] raiseTrapCode,
	output logic raiseIsInt,
	output logic [3:0] raiseIntVec,
	output logic [15:0] intPending,
	output logic fpErrPending
);

	// Refuse a reporting style the decoder cannot serve
	generate
		if (UIA_STYLE > ipr_pkg::UIA_ON_FETCH) begin : g_bad_style
			$error("UIA_STYLE out of range");
		end
	endgenerate

	// ==================================================
	// Bundle slot candidates
	logic [8:0] slotKey [3];
	logic [2:0] slotLive;

	// Qualify each slot: predicate, deferral, frame origin
	genvar s;
	generate
		for (s = 0; s < 3; s++) begin : g_slot
			wire logic [6:0] p = slotPrio[s*7 +: 7];
			wire logic iframe = p >= ipr_pkg::IFRAME_LO &&
				p <= ipr_pkg::IFRAME_HI;
			assign slotLive[s] = slotValid[s] &&
				!(slotPredSens[s] && !slotPred[s]) && // see [RL4]
				!slotDeferred[s] && // see [RL21]
				!(iframe && !slotFromReturn[s]); // see [RL6]
			assign slotKey[s] = slotLive[s] ? {p, 2'(s)} : 9'h1FF;
		end
	endgenerate

	// ==================================================
	// Unimplemented instruction address candidate
	wire logic [6:0] uiaPrio = uiaOnCheck ?
		ipr_pkg::UIA_CHECK : // see [RL10]
		(UIA_STYLE == ipr_pkg::UIA_ON_FETCH) ? ipr_pkg::PRIO_UIA_FAULT :
		ipr_pkg::PRIO_UIA_TRAP; // see [RL8]
	wire logic [1:0] uiaSl = (UIA_STYLE == ipr_pkg::UIA_ON_SLOT2 &&
		!uiaOnCheck) ? ipr_pkg::SLOT_LAST : uiaSlot;
	wire logic [8:0] uiaKey = uiaDetect ? {uiaPrio, uiaSl} : 9'h1FF;

	// ==================================================
	// Legacy fetch class ordering
	wire logic tlbAny = lgTlbFirst || (lgSpans && lgTlbSecond);
	wire logic codeWins = lgCodeFault && (lgStartOver || // see [RL13]
		(!lgTlbFirst && !(lgSpans && lgTlbSecond && // see [RL14]
		!lgLimitAtBound)));
	wire logic [6:0] fetchPrio = lgIbrk ? ipr_pkg::PRIO_LG_IBRK :
		codeWins ? ipr_pkg::PRIO_LG_CODE :
		tlbAny ? ipr_pkg::PRIO_LG_ITLB :
		lgCodeFault ? ipr_pkg::PRIO_LG_CODE :
		ipr_pkg::PRIO_NONE; // see [RL12]
	wire logic fetchAny = lgIbrk || lgCodeFault || tlbAny;

	// Length fault over second-page translation
	wire logic manyPrefix = lgPrefixBytes >= ipr_pkg::PRIO_LEN_MIN[3:0];
	wire logic lenPreempt = lgLenFault && lgSpans && lgTlbSecond &&
		!lgTlbFirst && !lgIbrk && !codeWins &&
		(manyPrefix || LEN_FIRST); // see [RL15] see [RL16]

	// First data reference or page checked before the next
	wire logic [6:0] refPrio =
		lgRefFault[0] ? lgRefPrio[6:0] : // see [RL18]
		lgRefFault[1] ? lgRefPrio[13:7] : // see [RL19]
		ipr_pkg::PRIO_NONE; // see [RL17]

	// Legacy traps: first set bit picks priority, all are reported
	logic [6:0] trapPrio;
	always_comb begin
		trapPrio = ipr_pkg::PRIO_NONE;
		for (int i = ipr_pkg::NTRAP - 1; i >= 0; i--) begin
			if (lgTraps[i]) begin
				trapPrio = ipr_pkg::LG_TRAP_BASE + 7'(i); // see [RL7]
			end
		end
	end

	// Classes in fixed order: fetch, decode, execute, trap, except that a length fault can beat a second-page translation fault
	wire logic [6:0] lgPrio = lenPreempt ? ipr_pkg::PRIO_LG_LEN :
		fetchAny ? fetchPrio :
		lgLenFault ? ipr_pkg::PRIO_LG_LEN :
		(|lgRefFault) ? refPrio : trapPrio; // see [RL11]
	wire logic lgAny = lgValid && lgPrio != ipr_pkg::PRIO_NONE;
	wire logic [8:0] lgKey = lgAny ? {lgPrio, 2'h0} : 9'h1FF;
	wire logic lgTrapWin = lgAny && lgPrio >= ipr_pkg::LG_TRAP_BASE;

	// ==================================================
	// Float error deferred to the next wait operation
	wire logic fpFire = fpErrPending && fpWaitInsn; // see [RL9]
	wire logic [8:0] fpKey = fpFire ? {ipr_pkg::PRIO_FP_ERR, 2'h0} :
		9'h1FF;

	// ==================================================
	// Pending interrupts, highest vector first
	logic [3:0] intTop;
	always_comb begin
		intTop = 4'h0;
		for (int i = 0; i < ipr_pkg::NINT; i++) begin
			if (intPending[i]) begin
				intTop = 4'(i);
			end
		end
	end
	wire logic [8:0] intKey = (|intPending) ?
		{ipr_pkg::PRIO_INT, 2'h0} : 9'h1FF;

	// ==================================================
	// Encoder: smallest {priority, slot} wins
	logic [8:0] bestKey;
	logic [2:0] bestSrc;
	always_comb begin
		bestKey = intKey;
		bestSrc = 3'h4;
		if (uiaKey < bestKey) begin
			bestKey = uiaKey;
			bestSrc = 3'h5;
		end
		if (lgKey < bestKey) begin
			bestKey = lgKey;
			bestSrc = 3'h3;
		end
		if (fpKey < bestKey) begin
			bestKey = fpKey;
			bestSrc = 3'h6;
		end
		for (int i = ipr_pkg::NSLOT - 1; i >= 0; i--) begin
			if (slotKey[i] <= bestKey) begin
				bestKey = slotKey[i]; // see [RL2] see [RL22]
				bestSrc = 3'(i);
			end
		end
	end
	wire logic anyWin = bestKey != 9'h1FF; // see [RL1]
	wire logic intWin = anyWin && bestSrc == 3'h4;

	// Interrupt pend set wins over delivery clear
	logic [15:0] intSet;
	logic [15:0] intClr;
	assign intSet = intReq ? (16'h0001 << intVec) : 16'h0000;
	assign intClr = intWin ? (16'h0001 << intTop) : 16'h0000;
	wire logic [15:0] next_intPending =
		(intPending & ~intClr) | intSet; // see [RL3]
	wire logic next_fpErr = fpErrDetect || (fpErrPending && !(fpFire &&
		bestSrc == 3'h6)); // see [RL9]

	// ==================================================
	// State and registered outputs
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			intPending <= 16'h0000;
			fpErrPending <= 1'b0;
			raiseValid <= 1'b0;
			raisePrio <= ipr_pkg::PRIO_NONE;
			raiseSlot <= 2'h0;
			raiseVector <= 7'h00;
			raiseTrapCode <= 8'h00;
			raiseIsInt <= 1'b0;
			raiseIntVec <= 4'h0;
		end else begin
			intPending <= next_intPending;
			fpErrPending <= next_fpErr;
			raiseValid <= anyWin;
			raisePrio <= bestKey[8:2];
			raiseSlot <= bestKey[1:0];
			raiseVector <= ipr_pkg::vec_of(bestKey[8:2]); // see [RL5]
			raiseTrapCode <= (bestSrc == 3'h3 && lgTrapWin) ?
				lgTraps : 8'h00; // see [RL20]
			raiseIsInt <= intWin;
			raiseIntVec <= intTop;
		end
	end

	// ==================================================
	// Checks
	// Interrupt arrival, then its pend bit one edge later
	sequence s_intArrive;
		intReq;
	endsequence
	sequence s_pendSeen;
		##1 intPending[$past(intVec)];
	endsequence

	// Float error, then a wait with no rival candidate
	sequence s_fpErrSeen;
		fpErrDetect;
	endsequence
	sequence s_quietWait;
		fpWaitInsn && slotValid == 3'h0 && !lgValid && !uiaDetect &&
		intPending == 16'h0000;
	endsequence

	// Arriving interrupts always pend
	a_int_kept_pending: assert property ( // see [RL3]
		@(posedge ref_clk) disable iff (rst)
		s_intArrive |-> s_pendSeen)
		else $error("arriving interrupt not pended");

	// Pending interrupts leave only when delivered
	a_int_held: assert property ( // see [RL3]
		@(posedge ref_clk) disable iff (rst)
		!intWin |=> (intPending & $past(intPending)) == $past(intPending))
		else $error("pending interrupt lost");

	a_pred_off_drop: assert property ( // see [RL4]
		@(posedge ref_clk) disable iff (rst)
		(slotValid[0] && slotPredSens[0] && !slotPred[0]) |->
		!slotLive[0])
		else $error("predicated-off slot still live");

	a_deferred_out: assert property ( // see [RL21]
		@(posedge ref_clk) disable iff (rst)
		(anyWin && bestSrc < 3'h3) |-> !slotDeferred[bestSrc[1:0]])
		else $error("deferred fault was raised");

	a_slot_order: assert property ( // see [RL2]
		@(posedge ref_clk) disable iff (rst)
		(slotLive[0] && slotLive[1] &&
		slotPrio[6:0] == slotPrio[13:7]) |-> bestSrc != 3'h1)
		else $error("higher slot won a tie");

	a_iframe_source: assert property ( // see [RL6]
		@(posedge ref_clk) disable iff (rst)
		(slotValid[0] && !slotFromReturn[0] &&
		slotPrio[6:0] == ipr_pkg::IFRAME_LO) |-> !slotLive[0])
		else $error("incomplete frame without return");

	a_iframe_vector: assert property ( // see [RL5]
		@(posedge ref_clk) disable iff (rst)
		(raiseValid && raisePrio == ipr_pkg::IFRAME_LO) |->
		raiseVector == ipr_pkg::STACK_FIRST)
		else $error("incomplete frame vector wrong");

	a_debug_shared: assert property ( // see [RL7]
		@(posedge ref_clk) disable iff (rst)
		(raiseValid && raisePrio > ipr_pkg::LG_DEBUG &&
		raisePrio < ipr_pkg::UIA_CHECK) |->
		raiseVector == ipr_pkg::LG_DEBUG)
		else $error("debug traps not sharing vector");

	a_trap_code: assert property ( // see [RL20]
		@(posedge ref_clk) disable iff (rst)
		(lgTrapWin && bestSrc == 3'h3) |=>
		raiseTrapCode == $past(lgTraps))
		else $error("concurrent traps not reported");

	a_fp_on_wait: assert property ( // see [RL9]
		@(posedge ref_clk) disable iff (rst)
		s_fpErrSeen ##1 s_quietWait |=>
		raiseValid && raisePrio == ipr_pkg::PRIO_FP_ERR)
		else $error("float error not raised on wait");

	a_one_winner: assert property ( // see [RL1]
		@(posedge ref_clk) disable iff (rst)
		(intWin && !intReq) |=> $countones($past(intPending) &
		~intPending) == 1)
		else $error("more than one interrupt taken");

	a_code_first: assert property ( // see [RL13]
		@(posedge ref_clk) disable iff (rst)
		(lgValid && lgCodeFault && lgStartOver && !lgIbrk) |->
		lgPrio == ipr_pkg::PRIO_LG_CODE)
		else $error("code fetch not first beyond limit");

	a_len_prefix: assert property ( // see [RL15]
		@(posedge ref_clk) disable iff (rst)
		(lgValid && lgLenFault && lgSpans && lgTlbSecond && !lgTlbFirst &&
		!lgIbrk && !lgCodeFault && manyPrefix) |->
		lgPrio == ipr_pkg::PRIO_LG_LEN)
		else $error("length fault not ahead of page two");

endmodule

// *** ipr_core_model.sv ***
/*
 * Core model: presents the slot conditions of one bundle to the resolver.
 * Assumes the bench changes requests just after ref_clk rises.
 */
`timescale 1ns/1ps
module ipr_core_model (
	input wire logic ref_clk,
	input wire logic present,
	input wire logic [2:0] reqValid,
	input wire logic [20:0] reqPrio,
	input wire logic [2:0] reqSens,
	input wire logic [2:0] reqPred,
	input wire logic [2:0] reqDef,
	input wire logic [2:0] reqRet,
	output logic [2:0] slotValid,
	output logic [20:0] slotPrio,
	output logic [2:0] slotPredSens,
	output logic [2:0] slotPred,
	output logic [2:0] slotDeferred,
	output logic [2:0] slotFromReturn
);
	// ==================================================
	// Idle noise, so stale fields never look steady
	logic noise = 1'b0;
	always @(posedge ref_clk) begin
		noise <= ~noise;
	end

	// Bundle fields while presenting; otherwise valid cleared, other fields changing junk
	assign slotValid = present ? reqValid : 3'h0;
	assign slotPrio = present ? reqPrio : {21{noise}};
	assign slotPredSens = present ? reqSens : {3{noise}};
	assign slotPred = present ? reqPred : {3{~noise}};
	assign slotDeferred = present ? reqDef : {3{noise}};
	assign slotFromReturn = present ? reqRet : {3{~noise}};
endmodule

// *** interruption_priority_resolver_bench.sv ***
/*
 * Self-checking bench for the interruption priority resolver.
 * Assumes the resolver answers just after the edge that samples its inputs.
 */
`timescale 1ns/1ps
module interruption_priority_resolver_bench;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic present = 1'b0;
	logic [2:0] reqValid = 3'h0, reqSens = 3'h0, reqPred = 3'h0;
	logic [2:0] reqDef = 3'h0, reqRet = 3'h0, slotIsTrap = 3'h0;
	logic [20:0] reqPrio = 21'h0;
	logic intReq = 1'b0, uiaDetect = 1'b0, uiaOnCheck = 1'b0;
	logic lgValid = 1'b0, lgIbrk = 1'b0, lgCodeFault = 1'b0;
	logic lgTlbFirst = 1'b0, lgTlbSecond = 1'b0, lgSpans = 1'b0;
	logic lgStartOver = 1'b0, lgLimitAtBound = 1'b0, lgLenFault = 1'b0;
	logic fpErrDetect = 1'b0, fpWaitInsn = 1'b0;
	logic [3:0] intVec = 4'h0, lgPrefixBytes = 4'h0;
	logic [1:0] uiaSlot = 2'h0, lgRefFault = 2'h0;
	logic [13:0] lgRefPrio = 14'h0;
	logic [7:0] lgTraps = 8'h00;
	logic [2:0] slotValid, slotPredSens, slotPred, slotDeferred;
	logic [2:0] slotFromReturn;
	logic [20:0] slotPrio;
	logic raiseValid, raiseIsInt, fpErrPending;
	logic [6:0] raisePrio, raiseVector;
	logic [1:0] raiseSlot;
	logic [7:0] raiseTrapCode;
	logic [3:0] raiseIntVec;
	logic [15:0] intPending;
	int seed = 78;
	int badCount = 0;
	int comparisons = 0;
	logic [9:0] e;

	ipr_core_model core (.ref_clk, .present, .reqValid, .reqPrio, .reqSens,
		.reqPred, .reqDef, .reqRet, .slotValid, .slotPrio, .slotPredSens,
		.slotPred, .slotDeferred, .slotFromReturn);

	ipr_resolver DUT (.ref_clk, .rst, .slotValid, .slotPrio, .slotIsTrap,
		.slotPredSens, .slotPred, .slotDeferred, .slotFromReturn, .intReq,
		.intVec, .uiaDetect, .uiaOnCheck, .uiaSlot, .lgValid, .lgIbrk,
		.lgCodeFault, .lgTlbFirst, .lgTlbSecond, .lgSpans, .lgStartOver,
		.lgLimitAtBound, .lgLenFault, .lgPrefixBytes, .lgRefFault, .lgRefPrio,
		.lgTraps, .fpErrDetect, .fpWaitInsn, .raiseValid, .raisePrio,
		.raiseSlot, .raiseVector, .raiseTrapCode, .raiseIsInt, .raiseIntVec,
		.intPending, .fpErrPending);

	// ==================================================
	// Helpers
	task automatic step();
		@(posedge ref_clk);
		#1;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			badCount++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Expected {valid, slot, priority} of the presented bundle
	function automatic logic [9:0] exp_slot();
		logic [6:0] p, best;
		logic [1:0] bs;
		logic ok;
		best = 7'h7F;
		bs = 2'h0;
		for (int s = 0; s < 3; s++) begin
			p = reqPrio[s*7+:7];
			ok = reqValid[s] && !reqDef[s] && !(reqSens[s] && !reqPred[s]);
			ok = ok && !(p >= 7'h07 && p <= 7'h12 && !reqRet[s]);
			if (ok && p < best) begin
				best = p;
				bs = 2'(s);
			end
		end
		return {best != 7'h7F, bs, best};
	endfunction

	function automatic logic [6:0] vexp(input logic [6:0] p);
		if (p == 7'h07) return 7'h2D;
		if (p >= 7'h08 && p <= 7'h10) return p + 7'h2B;
		if (p == 7'h11 || p == 7'h12) return p + 7'h2C;
		if (p == 7'h53 || p == 7'h54) return 7'h52;
		return p;
	endfunction

	function automatic logic [6:0] trap_prio(input logic [7:0] t);
		logic [6:0] r;
		r = 7'h7F;
		for (int j = 7; j >= 0; j--) if (t[j]) r = 7'h4D + 7'(j);
		return r;
	endfunction

	// Legacy fetch/decode flags, then expected winning priority
	task automatic lg(input logic [7:0] f, input logic [3:0] pb,
		input logic [6:0] ex);
		{lgIbrk, lgCodeFault, lgTlbFirst, lgTlbSecond} = f[7:4];
		{lgSpans, lgStartOver, lgLimitAtBound, lgLenFault} = f[3:0];
		lgPrefixBytes = pb;
		step();
		chk(raisePrio, ex);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, badCount);
		if (badCount == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// ==================================================
	// Clock and watchdog (tests need about 130 cycles)
	initial forever #20 ref_clk = ~ref_clk;
	initial begin
		#100000;
		badCount++;
		print_verdict();
	end

	// Main sequence
	initial begin
		repeat (3) step();
		chk(raisePrio, 7'h7F);
		rst = 1'b0;
		present = 1'b1;
		// Corner: the same priority in every slot
		reqValid = 3'h7;
		reqPrio = {7'h15, 7'h15, 7'h15};
		step();
		chk(raiseSlot, 2'h0);
		chk(raisePrio, 7'h15);
		repeat (80) begin
			{reqValid, reqSens, reqPred, reqDef} = 12'($random(seed));
			{reqRet, slotIsTrap} = 6'($random(seed));
			for (int s = 0; s < 3; s++)
				reqPrio[s*7+:7] = 7'h07 + 7'($random(seed) & 31);
			e = exp_slot();
			step();
			chk(raiseValid, e[9]);
			if (e[9]) begin
				chk(raisePrio, e[6:0]);
				chk(raiseSlot, e[8:7]);
				chk(raiseVector, vexp(e[6:0]));
			end
		end
		$display("test random bundles done");
		reqValid = 3'h2;
		reqDef = 3'h0;
		reqSens = 3'h0;
		reqPrio[13:7] = 7'h02;
		intReq = 1'b1;
		intVec = 4'h3;
		step();
		intReq = 1'b0;
		chk(raisePrio, 7'h02);
		step();
		chk(intPending, 16'h0008);
		present = 1'b0;
		step();
		chk({raiseIsInt, raiseIntVec, raisePrio}, 12'h984);
		step();
		chk(raiseValid, 1'b0);
		chk(intPending, 16'h0000);
		$display("test interrupts done");
		lgValid = 1'b1;
		for (int i = 0; i < 18; i++) begin
			lgTraps = i < 8 ? 8'h01 << i : 8'($random(seed)) | 8'h40;
			step();
			chk(raisePrio, trap_prio(lgTraps));
			chk(raiseVector, vexp(trap_prio(lgTraps)));
			chk(raiseTrapCode, lgTraps);
		end
		uiaDetect = 1'b1;
		uiaOnCheck = 1'b1;
		lgTraps = 8'h80;
		step();
		chk(raisePrio, 7'h54);
		lgTraps = 8'h00;
		step();
		chk(raisePrio, 7'h55);
		uiaOnCheck = 1'b0;
		step();
		chk(raisePrio, 7'h4C);
		uiaDetect = 1'b0;
		$display("test traps done");
		lg(8'h5A, 4'h0, 7'h1B);
		lg(8'h58, 4'h0, 7'h1C);
		lg(8'h6C, 4'h0, 7'h1B);
		lg(8'h68, 4'h0, 7'h1C);
		lg(8'hE0, 4'h0, 7'h1A);
		lg(8'h19, 4'hF, 7'h20);
		lg(8'h19, 4'hE, 7'h20);
		lgTraps = 8'h01;
		lg(8'h40, 4'h0, 7'h1B);
		lgTraps = 8'h00;
		lgRefPrio = {7'h25, 7'h2A};
		lgRefFault = 2'h3;
		lg(8'h00, 4'h0, 7'h2A);
		lgRefFault = 2'h2;
		lg(8'h00, 4'h0, 7'h25);
		lgRefFault = 2'h0;
		lgValid = 1'b0;
		$display("test legacy classes done");
		fpErrDetect = 1'b1;
		step();
		fpErrDetect = 1'b0;
		chk(fpErrPending, 1'b1);
		step();
		chk(raiseValid, 1'b0);
		fpWaitInsn = 1'b1;
		step();
		fpWaitInsn = 1'b0;
		chk(raisePrio, 7'h30);
		step();
		chk(fpErrPending, 1'b0);
		// Error followed at once by a wait
		fpErrDetect = 1'b1;
		step();
		fpErrDetect = 1'b0;
		fpWaitInsn = 1'b1;
		step();
		fpWaitInsn = 1'b0;
		chk(raisePrio, 7'h30);
		rst = 1'b1;
		step();
		rst = 1'b0;
		chk(raisePrio, 7'h7F);
		chk(fpErrPending, 1'b0);
		$display("test float wait and reset done");
		print_verdict();
	end
endmodule
